/* rtl/ist_pkg.sv */
// Package: constants and carrier types of the interrupt status flag block
package ist_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [9:0] IST_OFS_FLAGS = 10'h058;
    localparam logic [9:0] IST_OFS_ENABLE = 10'h05C;
    localparam logic [31:0] IST_FLAGS_RESET = 32'h0000_0000;
    localparam logic [31:0] IST_ENABLE_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int IST_BIT_SWREQ = 31;
    localparam int IST_BIT_READY = 30;
    localparam int IST_BIT_TSU = 29;
    localparam int IST_BIT_FABRIC = 28;
    localparam int IST_BIT_PHY2 = 27;
    localparam int IST_BIT_PHY1 = 26;
    localparam int IST_BIT_TXHALT = 25;
    localparam int IST_BIT_RXHALT = 24;
    localparam int IST_BIT_DROPHALF = 23;
    localparam int IST_BIT_TXLOAD = 21;
    localparam int IST_BIT_RXCOUNT = 20;
    localparam int IST_BIT_TIMER = 19;
    localparam int IST_BIT_POWER = 17;
    localparam int IST_BIT_TXSOVF = 16;
    localparam int IST_BIT_RXOVS = 15;

    // Sticky write-one-to-clear bits and read-only summary bits
    localparam logic [31:0] IST_W1C_MASK = 32'hC3BB_8000;
    localparam logic [31:0] IST_RO_MASK = 32'h3C00_0000;
    localparam logic [31:0] IST_POWER_MASK = 32'h0002_0000;

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    localparam logic [15:0] IST_TIMER_ZERO = 16'h0000;
    localparam logic [15:0] IST_TIMER_MAX = 16'hFFFF;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [9:0] addr;
        logic [31:0] wdata;
    } ist_bus_req_t;

    typedef struct packed {
        logic ts_event;
        logic fabric_event;
        logic port2_phy_event;
        logic port1_phy_event;
        logic tx_halt_req;
        logic tx_halted;
        logic rx_halted;
        logic drop_count_msb;
        logic tx_buf_done;
        logic completion_notify;
        logic rx_count_done;
        logic [15:0] timer_count_value;
        logic power_event;
        logic pmt_unmasked_pending;
        logic tx_status_overflow;
        logic rx_oversize;
        logic deassert_active;
    } ist_events_t;

endpackage

/* rtl/ist_sticky.sv */
// Module: one sticky write-one-to-clear flag bit
`timescale 1ns/1ps
module ist_sticky
    import ist_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_set,
    input wire logic i_clr,
    // Flag
    output logic o_flag
);

    logic flag_q;
    logic flag_d;

    // Set wins over a clear in the same cycle, so no event is lost
    always_comb begin
        flag_d = flag_q;
        if (i_clr) begin
            flag_d = 1'b0;
        end
        if (i_set) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign o_flag = flag_q;

endmodule

/* rtl/ist_rise.sv */
// Module: rising edge detector for a level from same-clock logic
`timescale 1ns/1ps
module ist_rise
    import ist_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Level in, pulse out
    input wire logic i_level,
    output logic o_pulse
);

    logic prev_q;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= i_level;
        end
    end

    assign o_pulse = i_level & ~prev_q;

endmodule

/* rtl/ist_flags.sv */
// Module: interrupt status flags with enable register and request outputs
`timescale 1ns/1ps

module ist_flags
    import ist_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Register port from the host interface
    input ist_bus_req_t i_bus,
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    // Event sources
    input ist_events_t i_events,
    // Requests
    output logic o_master_req,
    output logic o_irq_req
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] enable;
        logic [3:0] ro_flags;
        logic ready_pend;
        logic [15:0] timer_prev;
        logic [31:0] rdata;
        logic rvalid;
        logic master;
        logic irq;
    } ist_state_t;

    ist_state_t st_q;
    ist_state_t st_d;

    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] sticky;
    logic [31:0] flags;
    logic [31:0] pending;
    logic pend_any;
    logic pend_normal;
    logic pend_power;
    logic wr_flags;
    logic wr_enable;
    logic rd_hit;
    logic tx_halt_rise;
    logic rx_halt_rise;
    logic drop_half_rise;
    logic timer_wrap;
    logic swreq_rise;

    assign wr_flags = i_bus.wr && (i_bus.addr == IST_OFS_FLAGS);
    assign wr_enable = i_bus.wr && (i_bus.addr == IST_OFS_ENABLE);
    assign rd_hit = i_bus.rd;

    // ------------------------------------------------------------------
    // Event edges
    // ------------------------------------------------------------------
    ist_rise u_tx_halt_rise (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_level(i_events.tx_halt_req & i_events.tx_halted),
        .o_pulse(tx_halt_rise)
    );

    ist_rise u_rx_halt_rise (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_level(i_events.rx_halted),
        .o_pulse(rx_halt_rise)
    );

    ist_rise u_drop_half_rise (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_level(i_events.drop_count_msb),
        .o_pulse(drop_half_rise)
    );

    // Wrap is seen as zero followed by the maximum count
    assign timer_wrap = (st_q.timer_prev == IST_TIMER_ZERO)
        && (i_events.timer_count_value == IST_TIMER_MAX);

    // Only a 0 to 1 transition of the enable bit raises the request
    assign swreq_rise = wr_enable && i_bus.wdata[IST_BIT_SWREQ]
        && !st_q.enable[IST_BIT_SWREQ];

    // ------------------------------------------------------------------
    // Set and clear vectors
    // ------------------------------------------------------------------
    always_comb begin
        set_vec = 32'h0000_0000;
        set_vec[IST_BIT_SWREQ] = swreq_rise;
        set_vec[IST_BIT_READY] = st_q.ready_pend;
        set_vec[IST_BIT_TXHALT] = tx_halt_rise;
        set_vec[IST_BIT_RXHALT] = rx_halt_rise;
        set_vec[IST_BIT_DROPHALF] = drop_half_rise;
        set_vec[IST_BIT_TXLOAD] = i_events.tx_buf_done
            & i_events.completion_notify;
        set_vec[IST_BIT_RXCOUNT] = i_events.rx_count_done;
        set_vec[IST_BIT_TIMER] = timer_wrap;
        set_vec[IST_BIT_POWER] = i_events.power_event;
        set_vec[IST_BIT_TXSOVF] = i_events.tx_status_overflow;
        set_vec[IST_BIT_RXOVS] = i_events.rx_oversize;
        clr_vec = 32'h0000_0000;
        if (wr_flags) begin
            clr_vec = i_bus.wdata & IST_W1C_MASK;
        end
        // Power flag refuses its clear while control bits are still pending
        if (i_events.pmt_unmasked_pending) begin
            clr_vec[IST_BIT_POWER] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sticky flags, one cell per writable bit
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_flag
            if (IST_W1C_MASK[gi]) begin : g_sticky
                ist_sticky u_cell (
                    .i_core_clk(i_core_clk),
                    .i_rst(i_rst),
                    .i_set(set_vec[gi]),
                    .i_clr(clr_vec[gi]),
                    .o_flag(sticky[gi])
                );
            end else begin : g_none
                assign sticky[gi] = 1'b0;
            end
        end
    endgenerate

    // Reserved bits stay zero since neither mask covers them
    always_comb begin
        flags = sticky;
        flags[IST_BIT_TSU] = st_q.ro_flags[3];
        flags[IST_BIT_FABRIC] = st_q.ro_flags[2];
        flags[IST_BIT_PHY2] = st_q.ro_flags[1];
        flags[IST_BIT_PHY1] = st_q.ro_flags[0];
    end

    assign pending = flags & st_q.enable;
    assign pend_any = |pending;
    assign pend_normal = |(pending & ~IST_POWER_MASK);
    assign pend_power = |(pending & IST_POWER_MASK);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.ready_pend = 1'b0;
        st_d.timer_prev = i_events.timer_count_value;
        st_d.ro_flags = {i_events.ts_event, i_events.fabric_event,
            i_events.port2_phy_event, i_events.port1_phy_event};
        if (wr_enable) begin
            st_d.enable = i_bus.wdata;
        end
        st_d.rvalid = rd_hit;
        st_d.rdata = 32'h0000_0000;
        if (rd_hit && (i_bus.addr == IST_OFS_FLAGS)) begin
            st_d.rdata = flags;
        end else if (rd_hit && (i_bus.addr == IST_OFS_ENABLE)) begin
            st_d.rdata = st_q.enable;
        end
        st_d.master = pend_any;
        // Deassertion window only masks the ordinary sources
        st_d.irq = (pend_normal && !i_events.deassert_active) || pend_power;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q.enable <= IST_ENABLE_RESET;
            st_q.ro_flags <= 4'h0;
            st_q.ready_pend <= 1'b1;
            st_q.timer_prev <= IST_TIMER_ZERO;
            st_q.rdata <= 32'h0000_0000;
            st_q.rvalid <= 1'b0;
            st_q.master <= 1'b0;
            st_q.irq <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rdata;
    assign o_rvalid = st_q.rvalid;
    assign o_master_req = st_q.master;
    assign o_irq_req = st_q.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_swreq_set;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_enable && i_bus.wdata[31] && !st_q.enable[31]) |=> flags[31];
    endproperty
    a_swreq_set: assert property (p_swreq_set)
        else $error("software request flag not set");

    property p_ready_once;
        @(posedge i_core_clk) disable iff (i_rst)
        st_q.ready_pend |=> (flags[30] && !st_q.ready_pend);
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("ready flag not set after reset");

    property p_ro_mirror;
        @(posedge i_core_clk) disable iff (i_rst)
        ##1 flags[29:26] == $past(st_d.ro_flags);
    endproperty
    a_ro_mirror: assert property (p_ro_mirror)
        else $error("read-only summary bits do not follow sources");

    property p_w1c_clear;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_flags && i_bus.wdata[24] && flags[24] && !rx_halt_rise) |=> !flags[24];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear)
        else $error("receiver halt flag not cleared by write of one");

    property p_zero_write_keeps;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_flags && !i_bus.wdata[21] && flags[21]) |=> flags[21];
    endproperty
    a_zero_write_keeps: assert property (p_zero_write_keeps)
        else $error("write of zero changed a flag");

    property p_drop_half;
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(i_events.drop_count_msb) |=> flags[23] [*1];
    endproperty
    a_drop_half: assert property (p_drop_half)
        else $error("drop counter midpoint flag missing");

    property p_timer_wrap;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_events.timer_count_value == 16'hFFFF && st_q.timer_prev == 16'h0000)
            |=> flags[19];
    endproperty
    a_timer_wrap: assert property (p_timer_wrap)
        else $error("timer wrap flag missing");

    property p_power_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_flags && flags[17] && i_events.pmt_unmasked_pending) |=> flags[17];
    endproperty
    a_power_hold: assert property (p_power_hold)
        else $error("power flag cleared while control bits pending");

    property p_power_irq;
        @(posedge i_core_clk) disable iff (i_rst)
        (flags[17] && st_q.enable[17]) |=> o_irq_req;
    endproperty
    a_power_irq: assert property (p_power_irq)
        else $error("power flag request delayed");

    property p_master;
        @(posedge i_core_clk) disable iff (i_rst)
        ##1 o_master_req == $past(pend_any);
    endproperty
    a_master: assert property (p_master)
        else $error("master request does not follow enabled flags");

    property p_reserved_zero;
        @(posedge i_core_clk) disable iff (i_rst)
        o_rvalid |-> (o_rdata[22] == 1'b0 && o_rdata[18] == 1'b0
            && o_rdata[14:0] == 15'h0000) || $past(i_bus.addr) == IST_OFS_ENABLE;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_oversize;
        @(posedge i_core_clk) disable iff (i_rst)
        i_events.rx_oversize |=> flags[15] && !o_rvalid || flags[15];
    endproperty
    a_oversize: assert property (p_oversize)
        else $error("oversize receive flag missing");

endmodule

/* tb/ist_host_model.sv */
// Host CPU model issuing single-cycle register reads and writes
`timescale 1ns/1ps
module ist_host_model
    import ist_pkg::*;
(
    // Clock
    input wire logic i_core_clk,
    // Register port toward the flags block
    output ist_bus_req_t o_bus,
    input wire logic [31:0] i_rdata,
    input wire logic i_rvalid
);
    initial o_bus = '0;

    // Released fields carry inverted data so stale values never match
    task automatic write32(input logic [9:0] addr, input logic [31:0] data);
        @(negedge i_core_clk);
        o_bus = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(negedge i_core_clk);
        o_bus = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    task automatic read32(input logic [9:0] addr, output logic [31:0] data, output logic ok);
        @(negedge i_core_clk);
        o_bus = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 32'h0000_0000};
        @(negedge i_core_clk);
        o_bus = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 32'hFFFF_FFFF};
        ok = i_rvalid;
        data = i_rdata;
    endtask
endmodule

/* tb/ist_flags_tb.sv */
// Self-checking testbench of the interrupt status flag block
`timescale 1ns/1ps
module ist_flags_tb;
    import ist_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    ist_bus_req_t bus;
    ist_events_t ev = '0;
    logic [31:0] o_rdata;
    logic o_rvalid;
    logic o_master_req;
    logic o_irq_req;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] rd_val;
    logic rd_ok;
    int sticky[9] = '{15, 16, 17, 20, 21, 23, 24, 25, 19};

    always #2.5 i_core_clk = ~i_core_clk;

    ist_flags DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .i_events(ev), .o_master_req(o_master_req), .o_irq_req(o_irq_req));
    ist_host_model host (.i_core_clk(i_core_clk), .o_bus(bus), .i_rdata(o_rdata),
        .i_rvalid(o_rvalid));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] bit_of(input int b);
        return 32'h0000_0001 << b;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic read_at(input logic [9:0] addr, input logic [31:0] exp, input string what);
        host.read32(addr, rd_val, rd_ok);
        check({31'h0, rd_ok}, 32'h1, "read answer");
        check(rd_val, exp, what);
    endtask

    task automatic apply(input ist_events_t nx);
        @(negedge i_core_clk);
        ev = nx;
    endtask

    // One-cycle source pulse; full=0 leaves out the qualifying input
    task automatic pulse_src(input int b, input logic full);
        ist_events_t nx;
        nx = ev;
        case (b)
            IST_BIT_RXOVS: nx.rx_oversize = 1'b1;
            IST_BIT_TXSOVF: nx.tx_status_overflow = 1'b1;
            IST_BIT_POWER: nx.power_event = 1'b1;
            IST_BIT_RXCOUNT: nx.rx_count_done = 1'b1;
            IST_BIT_TXLOAD: {nx.tx_buf_done, nx.completion_notify} = {1'b1, full};
            IST_BIT_DROPHALF: nx.drop_count_msb = 1'b1;
            IST_BIT_RXHALT: nx.rx_halted = 1'b1;
            IST_BIT_TXHALT: {nx.tx_halted, nx.tx_halt_req} = {1'b1, full};
            default: nx.timer_count_value = IST_TIMER_ZERO;
        endcase
        apply(nx);
        nx = '0;
        nx.pmt_unmasked_pending = ev.pmt_unmasked_pending;
        nx.deassert_active = ev.deassert_active;
        if (b == IST_BIT_TIMER) begin
            nx.timer_count_value = IST_TIMER_MAX;
        end
        apply(nx);
        repeat (2) @(negedge i_core_clk);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Cut a hang short well beyond the expected run length
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            $display("wrong value at %0t: run did not finish", $time);
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] m;
        logic [31:0] en;
        logic d;
        ist_events_t nx;
        void'($urandom(32'h086c));
        repeat (3) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_rst = 1'b0;
        read_at(IST_OFS_FLAGS, bit_of(IST_BIT_READY), "ready after reset");
        host.write32(IST_OFS_FLAGS, bit_of(IST_BIT_READY));
        read_at(IST_OFS_FLAGS, 32'h0, "ready cleared");
        read_at(10'h100, 32'h0, "unmapped read");
        $display("test reset done");

        foreach (sticky[i]) begin
            if (sticky[i] == IST_BIT_TXLOAD || sticky[i] == IST_BIT_TXHALT) begin
                pulse_src(sticky[i], 1'b0);
                read_at(IST_OFS_FLAGS, 32'h0, "unqualified source");
            end
            pulse_src(sticky[i], 1'b1);
            read_at(IST_OFS_FLAGS, bit_of(sticky[i]), "flag set");
            host.write32(IST_OFS_FLAGS, ~bit_of(sticky[i]));
            read_at(IST_OFS_FLAGS, bit_of(sticky[i]), "zero write kept");
            host.write32(IST_OFS_FLAGS, bit_of(sticky[i]));
            read_at(IST_OFS_FLAGS, 32'h0, "flag cleared");
        end
        $display("test sticky done");

        for (int b = IST_BIT_PHY1; b <= IST_BIT_TSU; b++) begin
            nx = '0;
            {nx.ts_event, nx.fabric_event, nx.port2_phy_event, nx.port1_phy_event} =
                4'(bit_of(b) >> IST_BIT_PHY1);
            apply(nx);
            host.write32(IST_OFS_FLAGS, 32'hFFFF_FFFF);
            read_at(IST_OFS_FLAGS, bit_of(b), "mirror set");
            apply('0);
            read_at(IST_OFS_FLAGS, 32'h0, "mirror dropped");
        end
        $display("test mirror done");

        host.write32(IST_OFS_ENABLE, bit_of(IST_BIT_SWREQ));
        read_at(IST_OFS_FLAGS, bit_of(IST_BIT_SWREQ), "software request");
        check({31'h0, o_master_req}, 32'h1, "master request");
        host.write32(IST_OFS_FLAGS, bit_of(IST_BIT_SWREQ));
        read_at(IST_OFS_FLAGS, 32'h0, "software request cleared");
        $display("test software done");

        host.write32(IST_OFS_ENABLE, bit_of(IST_BIT_POWER) | bit_of(IST_BIT_RXOVS));
        nx = '0;
        nx.deassert_active = 1'b1;
        apply(nx);
        pulse_src(IST_BIT_RXOVS, 1'b1);
        check({o_master_req, o_irq_req}, 32'h2, "held by interval");
        nx.pmt_unmasked_pending = 1'b1;
        apply(nx);
        pulse_src(IST_BIT_POWER, 1'b1);
        check({31'h0, o_irq_req}, 32'h1, "power passes interval");
        host.write32(IST_OFS_FLAGS, bit_of(IST_BIT_POWER) | bit_of(IST_BIT_RXOVS));
        read_at(IST_OFS_FLAGS, bit_of(IST_BIT_POWER), "power clear refused");
        apply('0);
        host.write32(IST_OFS_FLAGS, bit_of(IST_BIT_POWER));
        read_at(IST_OFS_FLAGS, 32'h0, "power cleared");
        check({o_master_req, o_irq_req}, 32'h0, "requests dropped");
        $display("test power done");

        for (int r = 0; r < 24; r++) begin
            m = $urandom & 32'h0033_8000;
            en = $urandom & 32'h7FFF_FFFF;
            d = 1'($urandom);
            host.write32(IST_OFS_ENABLE, en);
            nx = '0;
            nx.deassert_active = d;
            {nx.tx_buf_done, nx.rx_count_done, nx.power_event} = {m[21], m[20], m[17]};
            {nx.completion_notify, nx.tx_status_overflow, nx.rx_oversize} = {m[21], m[16], m[15]};
            apply(nx);
            nx = '0;
            nx.deassert_active = d;
            apply(nx);
            repeat (2) @(negedge i_core_clk);
            check({31'h0, o_master_req}, {31'h0, |(m & en)}, "random master");
            check({31'h0, o_irq_req}, {31'h0, (|(m & en & ~IST_POWER_MASK) & ~d) |
                (m[17] & en[17])}, "random request");
            read_at(IST_OFS_FLAGS, m, "random flags");
            host.write32(IST_OFS_FLAGS, m);
            read_at(IST_OFS_FLAGS, 32'h0, "random cleared");
        end
        $display("test random done");

        @(negedge i_core_clk);
        i_rst = 1'b1;
        @(negedge i_core_clk);
        i_rst = 1'b0;
        read_at(IST_OFS_FLAGS, bit_of(IST_BIT_READY), "ready after second reset");
        $display("test second reset done");
        test_done();
    end
endmodule
